// ==== core/bdu_core.sv ====
// Instruction sequencer for decimal adjust and decrement.
// Assumes a byte-wide synchronous memory: read data valid in the same cycle as
// the address, and the cycle of a write stands with rw_o low.
//
// Our own choices: the address map.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Decimal adjust adds correction to accumulator A.
// - Lower six added for digit A-F, or H with digit 0-3.
// - Upper six added and carry set, else clear.
// - Adjust sets negative from result bit seven.
// - Adjust is opcode 19, two read cycles.
// - Decrement subtracts one, stores back in place.
// - Decrement leaves carry flag unchanged.
// - Decrement updates negative, zero, overflow only.
// - Overflow set only when operand was 80.
// - Opcodes 4A, 5A, 7A, 6A, 18 6A.
// - Memory decrement: read, dummy FFFF, write back.
module bdu_core
	import bdu_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  rdata_i,
	input  wire logic [15:0] index_x_i,
	input  wire logic [15:0] index_y_i,
	output logic      [15:0] addr_o,
	output logic      [7:0]  wdata_o,
	output logic             rw_o,
	output logic      [7:0]  accumulator_a_o,
	output logic      [7:0]  accumulator_b_o,
	output logic      [7:0]  flag_register_o,
	output logic      [15:0] pc_o,
	output logic             illegal_o,
	output logic             retire_o
);
	bdu_state_t  state;
	bdu_state_t  next_state;
	logic [15:0] next_addr;
	logic        next_rw;
	logic [7:0]  opcode;
	logic        use_y;
	logic [7:0]  hi_byte;
	logic [15:0] target;
	logic [7:0]  operand;
	logic [7:0]  fix_sum;
	logic        fix_carry;
	logic [7:0]  dec_src;
	logic [7:0]  dec_res;
	logic        dec_n;
	logic        dec_z;
	logic        dec_v;
	logic        is_known;

	bdu_bcd_fix u_fix (
		.acc_i   (accumulator_a_o),
		.carry_i (flag_register_o[FLG_C]),
		.half_i  (flag_register_o[FLG_H]),
		.sum_o   (fix_sum),
		.carry_o (fix_carry)
	);

	always_comb begin
		dec_src = operand;
		if (state == BDU_INH && opcode == OPC_DEC_A) begin
			dec_src = accumulator_a_o;
		end else if (state == BDU_INH && opcode == OPC_DEC_B) begin
			dec_src = accumulator_b_o;
		end
	end

	bdu_dec u_dec (
		.opnd_i (dec_src),
		.res_o  (dec_res),
		.neg_o  (dec_n),
		.zero_o (dec_z),
		.ovf_o  (dec_v)
	);

	// Opcodes handled by this unit; any other stops the sequencer.
	always_comb begin
		is_known = (rdata_i == OPC_BCD_FIXUP) || (rdata_i == OPC_DEC_A)
			|| (rdata_i == OPC_DEC_B) || (rdata_i == OPC_DEC_EXT)
			|| (rdata_i == OPC_DEC_IDX);
	end

	// Each state names the bus cycle whose data arrive in it.
	always_comb begin
		next_state = state;
		next_addr = addr_o;
		next_rw = 1'b1;
		case (state)
			BDU_FETCH: begin
				if (rdata_i == OPC_PREBYTE_Y && !use_y) begin
					next_state = BDU_PRE;
					next_addr = addr_o + ONE16;
				end else if (!is_known || (use_y && rdata_i != OPC_DEC_IDX)) begin
					next_state = BDU_HALT;
				end else if (rdata_i == OPC_DEC_EXT) begin
					next_state = BDU_HI;
					next_addr = addr_o + ONE16;
				end else if (rdata_i == OPC_DEC_IDX) begin
					next_state = BDU_OFS;
					next_addr = addr_o + ONE16;
				end else begin
					next_state = BDU_INH;
					next_addr = addr_o + ONE16;
				end
			end
			BDU_PRE: begin
				// Only the Y-indexed form may follow the prebyte.
				if (rdata_i == OPC_DEC_IDX) begin
					next_state = BDU_OFS;
					next_addr = addr_o + ONE16;
				end else begin
					next_state = BDU_HALT;
				end
			end
			BDU_INH: begin
				next_state = BDU_FETCH;
				next_addr = addr_o;
			end
			BDU_HI: begin
				next_state = BDU_LO;
				next_addr = addr_o + ONE16;
			end
			BDU_LO: begin
				next_state = BDU_READ;
				next_addr = {hi_byte, rdata_i};
			end
			BDU_OFS: begin
				next_state = BDU_IDLE;
				next_addr = DUMMY_ADDR;
			end
			BDU_IDLE: begin
				next_state = BDU_READ;
				next_addr = target;
			end
			BDU_READ: begin
				next_state = BDU_DUMMY;
				next_addr = DUMMY_ADDR;
			end
			BDU_DUMMY: begin
				next_state = BDU_WRITE;
				next_addr = target;
				next_rw = 1'b0;
			end
			BDU_WRITE: begin
				next_state = BDU_FETCH;
				next_addr = pc_o;
			end
			BDU_HALT: begin
				next_state = BDU_HALT;
			end
			default: begin
				next_state = BDU_HALT;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= BDU_FETCH;
		end else begin
			state <= next_state;
		end
	end

	// Address and direction leave flip-flops so the bus never glitches.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			addr_o <= PC_RESET;
			rw_o <= 1'b1;
		end else begin
			addr_o <= next_addr;
			rw_o <= next_rw;
		end
	end

	// Opcode capture; the Y flag lives until the operation retires.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			opcode <= ZERO8;
			use_y <= 1'b0;
		end else begin
			case (state)
				BDU_FETCH: begin
					opcode <= rdata_i;
					if (rdata_i == OPC_PREBYTE_Y && !use_y) begin
						use_y <= 1'b1;
					end
				end
				BDU_PRE: begin
					opcode <= rdata_i;
				end
				BDU_INH, BDU_WRITE: begin
					use_y <= 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	// The program counter points past every byte taken from the stream.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc_o <= PC_RESET;
		end else if (state == BDU_FETCH || state == BDU_PRE
				|| state == BDU_HI || state == BDU_LO || state == BDU_OFS) begin
			pc_o <= addr_o + ONE16;
		end
	end

	// Effective address: extended bytes high first, or index plus offset.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hi_byte <= ZERO8;
			target <= PC_RESET;
		end else if (state == BDU_HI) begin
			hi_byte <= rdata_i;
		end else if (state == BDU_LO) begin
			target <= {hi_byte, rdata_i};
		end else if (state == BDU_OFS) begin
			// The index is sampled here; it need not hold after this cycle.
			target <= (use_y ? index_y_i : index_x_i) + {8'h00, rdata_i};
		end
	end

	// The target byte is kept for the decrementer until the write.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			operand <= ZERO8;
		end else if (state == BDU_READ) begin
			operand <= rdata_i;
		end
	end

	// The write data stand on the bus in the write cycle.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wdata_o <= ZERO8;
		end else if (state == BDU_DUMMY) begin
			wdata_o <= dec_res;
		end
	end

	// Accumulator A takes the adjusted sum or its own decrement.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			accumulator_a_o <= ZERO8;
		end else if (state == BDU_INH && opcode == OPC_BCD_FIXUP) begin
			accumulator_a_o <= fix_sum;
		end else if (state == BDU_INH && opcode == OPC_DEC_A) begin
			accumulator_a_o <= dec_res;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			accumulator_b_o <= ZERO8;
		end else if (state == BDU_INH && opcode == OPC_DEC_B) begin
			accumulator_b_o <= dec_res;
		end
	end

	// Flags; bits not named in a branch are never written here.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flag_register_o <= FLAGS_RESET;
		end else if (state == BDU_INH && opcode == OPC_BCD_FIXUP) begin
			flag_register_o[FLG_C] <= fix_carry;
			flag_register_o[FLG_N] <= fix_sum[7];
			flag_register_o[FLG_Z] <= (fix_sum == ZERO8);
			// V, H, I, X and S keep their values.
		end else if (state == BDU_INH || state == BDU_DUMMY) begin
			flag_register_o[FLG_N] <= dec_n;
			flag_register_o[FLG_Z] <= dec_z;
			flag_register_o[FLG_V] <= dec_v;
			// Carry untouched for loop counting.
		end
	end

	// One pulse for each completed instruction.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			retire_o <= 1'b0;
		end else begin
			retire_o <= (state == BDU_INH) || (state == BDU_WRITE);
		end
	end

	// Sticky: the halt state is left only through reset.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			illegal_o <= 1'b0;
		end else begin
			illegal_o <= (next_state == BDU_HALT);
		end
	end
endmodule // bdu_core
`default_nettype wire

// ==== core/bdu_pkg.sv ====
// Package for the decimal adjust and decrement unit.
// Holds opcodes, flag bit positions, bus constants and the sequencer states.
package bdu_pkg;
	localparam logic [7:0]  OPC_BCD_FIXUP = 8'h19;
	localparam logic [7:0]  OPC_DEC_A     = 8'h4a;
	localparam logic [7:0]  OPC_DEC_B     = 8'h5a;
	localparam logic [7:0]  OPC_DEC_EXT   = 8'h7a;
	localparam logic [7:0]  OPC_DEC_IDX   = 8'h6a;
	localparam logic [7:0]  OPC_PREBYTE_Y = 8'h18;
	localparam logic [15:0] DUMMY_ADDR    = 16'hffff;
	localparam logic [15:0] ONE16         = 16'h0001;
	localparam logic [7:0]  ONE8          = 8'h01;
	localparam logic [7:0]  ZERO8         = 8'h00;
	localparam logic [7:0]  OVF_OPERAND   = 8'h80;
	localparam logic [7:0]  FIX_LO        = 8'h06;
	localparam logic [7:0]  FIX_HI        = 8'h60;
	localparam logic [3:0]  NIB_NINE      = 4'h9;
	localparam logic [3:0]  NIB_EIGHT     = 4'h8;
	localparam logic [3:0]  NIB_THREE     = 4'h3;
	localparam logic [3:0]  NIB_TWO       = 4'h2;
	localparam logic [7:0]  FLAGS_RESET   = 8'hd0;
	localparam logic [15:0] PC_RESET      = 16'h0000;
	// Flag register bit positions: S X H I N Z V C.
	localparam int FLG_C = 0;
	localparam int FLG_V = 1;
	localparam int FLG_Z = 2;
	localparam int FLG_N = 3;
	localparam int FLG_H = 5;

	typedef enum logic [3:0] {
		BDU_FETCH  = 4'b0000,
		BDU_PRE    = 4'b0001,
		BDU_INH    = 4'b0010,
		BDU_HI     = 4'b0011,
		BDU_LO     = 4'b0100,
		BDU_OFS    = 4'b0101,
		BDU_IDLE   = 4'b0110,
		BDU_READ   = 4'b0111,
		BDU_DUMMY  = 4'b1000,
		BDU_WRITE  = 4'b1001,
		BDU_HALT   = 4'b1010
	} bdu_state_t;
endpackage : bdu_pkg

// ==== core/bdu_bcd_fix.sv ====
// Combinational correction for the decimal adjust operation.
// Assumes the flags and accumulator come from the preceding BCD addition.
`timescale 1ns/10ps
`default_nettype none
module bdu_bcd_fix
	import bdu_pkg::*;
(
	input  wire logic [7:0] acc_i,
	input  wire logic       carry_i,
	input  wire logic       half_i,
	output logic      [7:0] sum_o,
	output logic            carry_o
);
	logic [3:0] hi;
	logic [3:0] lo;
	logic       lo_fix;
	logic       hi_fix;
	logic [7:0] corr;

	always_comb begin
		hi = acc_i[7:4];
		lo = acc_i[3:0];
		lo_fix = (lo > NIB_NINE) || (half_i && lo <= NIB_THREE);
		hi_fix = carry_i || (hi > NIB_NINE && !(lo > NIB_NINE))
			|| (hi > NIB_EIGHT && lo > NIB_NINE)
			|| (hi > NIB_NINE && half_i);
		corr = ZERO8;
		if (lo_fix) begin
			corr = corr | FIX_LO;
		end
		if (hi_fix) begin
			corr = corr | FIX_HI;
		end
		sum_o = acc_i + corr;
		carry_o = hi_fix;
	end
endmodule // bdu_bcd_fix
`default_nettype wire

// ==== core/bdu_dec.sv ====
// Combinational decrement by one with flag results.
// Assumes an 8-bit operand from an accumulator or memory.
`timescale 1ns/10ps
`default_nettype none
module bdu_dec
	import bdu_pkg::*;
(
	input  wire logic [7:0] opnd_i,
	output logic      [7:0] res_o,
	output logic            neg_o,
	output logic            zero_o,
	output logic            ovf_o
);
	always_comb begin
		res_o = opnd_i - ONE8;
		neg_o = res_o[7];
		zero_o = (res_o == ZERO8);
		ovf_o = (opnd_i == OVF_OPERAND);
	end
endmodule // bdu_dec
`default_nettype wire

// ==== sim/bdu_mem_model.sv ====
// Byte-wide memory model on the far side of the core's bus.
// Assumes a registered address; read data follow it in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module bdu_mem_model (
	input  wire logic        clk_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        rw_i,
	output logic      [7:0]  rdata_o
);
	logic [7:0] mem [0:65535];
	logic [7:0] junk = 8'h5a;
	// A write cycle shows a toggling pattern, so a stale byte never matches.
	assign rdata_o = rw_i ? mem[addr_i] : junk;
	always @(posedge clk_i) begin
		junk <= ~junk;
		if (!rw_i)
			mem[addr_i] <= wdata_i;
	end
endmodule // bdu_mem_model
`default_nettype wire

// ==== sim/bdu_core_chk.sv ====
// Checker on the core's bus and flag ports.
// One clock; reset is asynchronous and active low.
`timescale 1ns/10ps
`default_nettype none
module bdu_core_chk
	import bdu_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic [7:0]  rdata_i,
	input wire logic [15:0] addr_o,
	input wire logic [7:0]  wdata_o,
	input wire logic        rw_o,
	input wire logic [7:0]  accumulator_a_o,
	input wire logic [7:0]  accumulator_b_o,
	input wire logic [7:0]  flag_register_o,
	input wire logic        illegal_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	dummy_read_a: assert property (
		!rw_o |-> $past(addr_o) == DUMMY_ADDR) else $error("no dummy read");
	write_addr_a: assert property (
		!rw_o |-> addr_o == $past(addr_o, 2)) else $error("bad write addr");
	write_once_a: assert property (
		!rw_o |=> rw_o) else $error("write cycle too long");
	write_data_a: assert property (
		!rw_o |-> wdata_o == $past(rdata_i, 2) - ONE8) else $error("bad data");
	a_flags_a: assert property (
		$changed(accumulator_a_o) |->
		flag_register_o[FLG_N] == accumulator_a_o[7] &&
		flag_register_o[FLG_Z] == !accumulator_a_o) else $error("bad A flags");
	b_step_a: assert property (
		$changed(accumulator_b_o) |->
		accumulator_b_o == $past(accumulator_b_o) - ONE8 &&
		flag_register_o[FLG_V] == ($past(accumulator_b_o) == OVF_OPERAND))
		else $error("bad B step");
	carry_keep_a: assert property (
		$changed(accumulator_b_o) || !rw_o |-> $stable(flag_register_o[FLG_C]))
		else $error("carry moved");
	fixed_flags_a: assert property (
		$stable(flag_register_o[7:4])) else $error("upper flags moved");
	halt_freeze_a: assert property (
		illegal_o |=> illegal_o && rw_o && $stable(addr_o))
		else $error("bus not frozen");
	cover property (!rw_o);
	cover property ($changed(accumulator_b_o));
	cover property (illegal_o);
	cover property ($changed(flag_register_o[FLG_C]));
endmodule // bdu_core_chk
bind bdu_core bdu_core_chk bdu_core_chk_inst (.clk_i, .rst_n_i, .rdata_i,
	.addr_o, .wdata_o, .rw_o, .accumulator_a_o, .accumulator_b_o,
	.flag_register_o, .illegal_o);
`default_nettype wire

// ==== sim/bdu_core_tb_top.sv ====
// Bench: a random instruction stream, state checked at every retire.
// Assumes program and data sit in the memory model before reset ends.
`timescale 1ns/10ps
`default_nettype none
module bdu_core_tb_top;
	import bdu_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [15:0] index_x_i = 16'h8000;
	logic [15:0] index_y_i = 16'h8100;
	logic [7:0]  rdata_i;
	logic [15:0] addr_o;
	logic [7:0]  wdata_o;
	logic        rw_o;
	logic [7:0]  acc_a;
	logic [7:0]  acc_b;
	logic [7:0]  flags;
	logic        illegal_o;
	logic        retire_o;
	logic [7:0]  ea, eb, ef;
	logic [15:0] pc;
	logic [7:0]  em [16'h8000:16'h82ff];
	logic [27:0] q [$];
	logic [27:0] exp_q;
	int          cyc = 0;
	logic [7:0]  opc [6] = '{OPC_BCD_FIXUP, OPC_DEC_A, OPC_DEC_B,
		OPC_DEC_EXT, OPC_DEC_IDX, OPC_DEC_IDX};
	int          miscompares = 0;
	int          total_checks = 0;

	always #2.5 clk_i = ~clk_i;

	bdu_core bdu_core_inst (.clk_i, .rst_n_i, .rdata_i, .index_x_i,
		.index_y_i, .addr_o, .wdata_o, .rw_o, .accumulator_a_o(acc_a),
		.accumulator_b_o(acc_b), .flag_register_o(flags), .pc_o(),
		.illegal_o, .retire_o);
	bdu_mem_model bdu_mem_model_inst (.clk_i, .addr_i(addr_o),
		.wdata_i(wdata_o), .rw_i(rw_o), .rdata_o(rdata_i));

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	function automatic logic [7:0] dec8(input logic [7:0] v);
		logic [7:0] r;
		r = v - ONE8;
		ef[FLG_N] = r[7];
		ef[FLG_Z] = r == ZERO8;
		ef[FLG_V] = v == OVF_OPERAND;
		return r;
	endfunction

	// Operands come from decrements, not a BCD add, so the boolean form
	// the core uses stands for pairs outside the legal sums.
	function automatic logic [7:0] bcd(input logic [7:0] a);
		logic hi;
		logic lo;
		logic [7:0] r;
		hi = ef[FLG_C] || a[7:4] > 4'h9 || (a[7:4] > 4'h8 && a[3:0] > 4'h9);
		lo = a[3:0] > 4'h9 || (ef[FLG_H] && a[3:0] < 4'h4);
		r = a + (lo ? FIX_LO : ZERO8);
		r = r + (hi ? FIX_HI : ZERO8);
		ef[FLG_C] = hi;
		ef[FLG_N] = r[7];
		ef[FLG_Z] = r == ZERO8;
		return r;
	endfunction

	task automatic put(input logic [7:0] b);
		bdu_mem_model_inst.mem[pc] = b;
		pc = pc + ONE16;
	endtask

	task automatic emit(input int k, input logic [7:0] t);
		logic [15:0] ta;
		logic [3:0]  cy;
		ta = {8'h82, t};
		cy = k < 3 ? 4'h2 : (k == 5 ? 4'h7 : 4'h6);
		if (k == 5)
			put(OPC_PREBYTE_Y);
		put(opc[k]);
		if (k == 3)
			put(8'h82);
		if (k > 2)
			put(t);
		if (k > 3)
			ta = (k == 4 ? index_x_i : index_y_i) + 16'(t);
		if (k == 0)
			ea = bcd(ea);
		else if (k == 1)
			ea = dec8(ea);
		else if (k == 2)
			eb = dec8(eb);
		else
			em[ta] = dec8(em[ta]);
		q.push_back({ea, eb, ef, cy});
	endtask

	// Cycles are counted from one retire pulse to the next.
	always @(negedge clk_i) begin
		if (retire_o === 1'b1 && q.size() > 0) begin
			exp_q = q.pop_front();
			check({acc_a, acc_b, flags}, exp_q[27:4]);
			check(24'(cyc), {20'h0, exp_q[3:0]});
			cyc = 1;
		end else if (rst_n_i) begin
			cyc++;
		end
	end

	initial begin
		void'($urandom(32'hb9c6));
		ea = ZERO8;
		eb = ZERO8;
		ef = FLAGS_RESET;
		pc = PC_RESET;
		@(posedge clk_i);
		index_x_i <= 16'h8000 + 16'($urandom_range(0, 63));
		index_y_i <= 16'h8100 + 16'($urandom_range(0, 63));
		@(posedge clk_i);
		for (int a = 16'h8000; a <= 16'h82ff; a++) begin
			em[a] = a == 16'h8200 ? OVF_OPERAND : 8'($urandom);
			bdu_mem_model_inst.mem[a] = em[a];
		end
		emit(2, 8'h00);
		emit(3, 8'h00);
		emit(3, 8'h00);
		emit(1, 8'h00);
		emit(0, 8'h00);
		emit(0, 8'h00);
		repeat (300)
			emit($urandom_range(0, 5), 8'($urandom));
		// An unsupported opcode ends the stream and must halt the core.
		put(ZERO8);
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 4000 && illegal_o !== 1'b1; i++)
			@(posedge clk_i);
		@(negedge clk_i);
		check({23'h0, illegal_o}, 24'h1);
		check(24'(q.size()), 24'h0);
		for (int a = 16'h8000; a <= 16'h82ff; a++)
			check({16'h0, bdu_mem_model_inst.mem[a]}, {16'h0, em[a]});
		$display("random instruction stream done");
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		finish_test();
	end
endmodule // bdu_core_tb_top
`default_nettype wire
